// *** verilog/kbl_pkg.sv ***
package kbl_pkg;
  // serial word layout
  localparam int KBL_WORD_BITS  = 9;
  localparam int KBL_DATA_BITS  = 8;
  localparam int KBL_KEY_BITS   = 7;
  localparam int KBL_STATUS_POS = 7;
  localparam logic KBL_STOP_LEVEL = 1'b1;
  localparam logic KBL_CLOSE_LEVEL = 1'b1;
  // timing
  localparam int KBL_CLK_MHZ        = 100;
  localparam int KBL_ACK_TIMEOUT_US = 20;
  localparam int KBL_ACK_TIMEOUT_CYC = KBL_ACK_TIMEOUT_US * KBL_CLK_MHZ;
  localparam int KBL_QUEUE_DEPTH    = 16;
  localparam int KBL_MAX_RETRIES    = 3;
  // reset values
  localparam logic [3:0] KBL_BIT_RST = 4'h0;
endpackage

// *** verilog/kbl_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface kbl_link_if;
  logic data;
  logic ready;
  logic ack;
  modport keyboard (output data, output ready, input ack);
  modport host     (input data, input ready, output ack);
endinterface
`default_nettype wire

// *** verilog/kbl_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module kbl_sync
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_level
);
  logic [2:0] sh_ff;
  // =====================================
  // three stages, change taken when last two agree
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      sh_ff <= 3'h0;
    else
      sh_ff <= {sh_ff[1:0], i_async};
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_level <= 1'b0;
    else if (sh_ff[1] == sh_ff[2])
      o_level <= sh_ff[2];
  end
endmodule
`default_nettype wire

// *** verilog/kbl_keyboard.sv ***
// Notes on behaviour
// - serial words of nine bit positions
// - eight data bits, lsb sent first
// - ninth position is stop bit
// - top byte bit is close/open status
// - low seven bits carry key number
// - only raw make/break events reported
// - pending events held in internal queue
// - bits presented on one data line
// - ready line says transfer is pending
// - host acknowledges each captured bit
// - queue full enters hold-off, nothing dropped
// - ack timeout resends the whole event
// - every press and release gives event
`timescale 1ns/1ps
`default_nettype none
module kbl_keyboard
  import kbl_pkg::*;
#(
  parameter int   DEPTH       = KBL_QUEUE_DEPTH,
  parameter int   TIMEOUT_CYC = KBL_ACK_TIMEOUT_CYC,
  parameter logic CLOSE_LEVEL = KBL_CLOSE_LEVEL
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ev_valid,
  input  wire logic       i_ev_closed,
  input  wire logic [6:0] i_ev_key,
  output logic            o_ev_ready,
  output logic            o_holdoff,
  output logic            o_retry,
  kbl_link_if.keyboard    link
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("kbl_keyboard: DEPTH must be a power of two >= 2");
    if (TIMEOUT_CYC < 2)
      $error("kbl_keyboard: TIMEOUT_CYC too small");
  end

  typedef enum logic [1:0]
  {
    KB_IDLE = 2'b00,
    KB_BIT  = 2'b01,
    KB_WAIT = 2'b10
  } kbl_state_e;

  logic [KBL_DATA_BITS-1:0] mem [DEPTH];
  logic [AW:0]              wr_ff;
  logic [AW:0]              rd_ff;
  logic                     full;
  logic                     empty;
  kbl_state_e               state_ff;
  logic [3:0]               bit_ff;
  logic [KBL_WORD_BITS-1:0] word_ff;
  logic [31:0]              tmo_ff;
  logic                     ack_s;
  logic                     ack_prev_ff;
  logic                     data_ff;
  logic                     ready_ff;
  logic                     push;
  logic                     pop;
  logic                     tmo_hit;

  kbl_sync u_ack_sync
  (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (link.ack),
    .o_level (ack_s)
  );

  // =====================================
  // event queue
  assign full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty = (wr_ff == rd_ff);
  assign push  = i_ev_valid && o_ev_ready && !full;
  assign pop   = (state_ff == KB_IDLE) && !empty;

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ff[AW-1:0]] <= {(i_ev_closed ? CLOSE_LEVEL : ~CLOSE_LEVEL), i_ev_key};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end

  // =====================================
  // hold-off while full: source stalls, no event is lost
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_ev_ready <= 1'b0;
      o_holdoff  <= 1'b0;
    end
    else
    begin
      o_ev_ready <= !(full || (wr_ff[AW-1:0] + 1'b1 == rd_ff[AW-1:0] && push));
      o_holdoff  <= full;
    end
  end

  // =====================================
  // serial sender, one bit per ack pulse: ack rise, then ack low
  assign tmo_hit = (state_ff != KB_IDLE) && (tmo_ff == 32'(TIMEOUT_CYC - 1));

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      ack_prev_ff <= 1'b0;
    else
      ack_prev_ff <= ack_s;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_ff <= KB_IDLE;
      bit_ff   <= KBL_BIT_RST;
      word_ff  <= '0;
      data_ff  <= KBL_STOP_LEVEL;
      ready_ff <= 1'b0;
      tmo_ff   <= '0;
      o_retry  <= 1'b0;
    end
    else
    begin
      o_retry <= 1'b0;
      tmo_ff  <= (state_ff == KB_IDLE || (ack_s != ack_prev_ff)) ? '0 : tmo_ff + 1'b1;
      unique case (state_ff)
        KB_IDLE:
        begin
          ready_ff <= 1'b0;
          if (pop)
          begin
            word_ff  <= {KBL_STOP_LEVEL, mem[rd_ff[AW-1:0]]};
            bit_ff   <= KBL_BIT_RST;
            data_ff  <= mem[rd_ff[AW-1:0]][0];
            state_ff <= KB_BIT;
          end
        end
        KB_BIT:
        begin
          ready_ff <= 1'b1;
          data_ff  <= word_ff[bit_ff];
          if (tmo_hit)
          begin
            bit_ff  <= KBL_BIT_RST;
            o_retry <= 1'b1;
          end
          else if (ack_s && !ack_prev_ff)
          begin
            ready_ff <= 1'b0;
            state_ff <= KB_WAIT;
          end
        end
        KB_WAIT:
        begin
          if (tmo_hit)
          begin
            bit_ff   <= KBL_BIT_RST;
            o_retry  <= 1'b1;
            state_ff <= KB_BIT;
          end
          else if (!ack_s)
          begin
            if (bit_ff == 4'(KBL_WORD_BITS - 1))
              state_ff <= KB_IDLE;
            else
            begin
              bit_ff   <= bit_ff + 4'h1;
              state_ff <= KB_BIT;
            end
          end
        end
        default:
          state_ff <= KB_IDLE;
      endcase
    end
  end

  assign link.data  = data_ff;
  assign link.ready = ready_ff;
endmodule
`default_nettype wire

// *** verilog/kbl_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module kbl_host
  import kbl_pkg::*;
#(
  parameter logic CLOSE_LEVEL = KBL_CLOSE_LEVEL
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  output logic            o_ev_valid,
  output logic            o_ev_closed,
  output logic [6:0]      o_ev_key,
  output logic            o_frame_err,
  kbl_link_if.host        link
);
  logic       rdy_s;
  logic       dat_s;
  logic       ack_ff;
  logic [3:0] cnt_ff;
  logic [8:0] sh_ff;

  kbl_sync u_rdy_sync
  (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (link.ready),
    .o_level (rdy_s)
  );

  kbl_sync u_dat_sync
  (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (link.data),
    .o_level (dat_s)
  );

  // =====================================
  // capture bit on ready, ack until ready drops
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ack_ff      <= 1'b0;
      cnt_ff      <= KBL_BIT_RST;
      sh_ff       <= '0;
      o_ev_valid  <= 1'b0;
      o_ev_closed <= 1'b0;
      o_ev_key    <= '0;
      o_frame_err <= 1'b0;
    end
    else
    begin
      o_ev_valid  <= 1'b0;
      o_frame_err <= 1'b0;
      if (rdy_s && !ack_ff)
      begin
        ack_ff <= 1'b1;
        sh_ff  <= {dat_s, sh_ff[8:1]};
        if (cnt_ff == 4'(KBL_WORD_BITS - 1))
        begin
          cnt_ff <= KBL_BIT_RST;
          if (dat_s == KBL_STOP_LEVEL)
          begin
            o_ev_valid  <= 1'b1;
            o_ev_closed <= (sh_ff[8] == CLOSE_LEVEL);
            o_ev_key    <= sh_ff[7:1];
          end
          else
            o_frame_err <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 4'h1;
      end
      else if (!rdy_s && ack_ff)
        ack_ff <= 1'b0;
    end
  end

  assign link.ack = ack_ff;
endmodule
`default_nettype wire

// *** bench/kbl_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module kbl_link_monitor
  import kbl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic data,
  input  wire logic ready,
  input  wire logic ack
);
  // ==========
  // bit counter
  logic       rdy_q_ff;
  logic [3:0] bit_ff;
  always_ff @(posedge i_clk)
    rdy_q_ff <= i_rstn & ready;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      bit_ff <= KBL_BIT_RST;
    else if (ready && !rdy_q_ff)
      bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
  end
  // ==========
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_take;
    ready ##[2:10] ack;
  endsequence
  chk_ack_answers: assert property ($rose(ready) |-> s_take)
    else $error("ack late");
  chk_ack_cause: assert property ($rose(ack) |-> ready)
    else $error("ack without ready");
  chk_ready_holds: assert property (ready && !ack |=> ready)
    else $error("ready dropped");
  chk_bit_stable: assert property (ready && !ack |=> $stable(data))
    else $error("data moved");
  chk_ready_drop: assert property ($rose(ack) |-> ##[1:10] !ready)
    else $error("ready stuck");
  chk_ack_release: assert property ($fell(ready) |-> ##[1:10] !ack)
    else $error("ack stuck");
  chk_wait_low: assert property (ack |-> !$rose(ready))
    else $error("bit before ack low");
  chk_stop_level: assert property (ready && !rdy_q_ff && bit_ff == 4'h8 |-> data == KBL_STOP_LEVEL)
    else $error("bad stop");
endmodule
`default_nettype wire

// *** bench/keyboard_event_serial_link_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module keyboard_event_serial_link_tb;
  import kbl_pkg::*;
  logic       clk, rstn, ev_valid, ev_closed, ev2_valid, k_ready, k_hold, k_retry;
  logic       k2_rdy, k2_retry, h_valid, h_closed, h_err, hold_seen, ack_q;
  logic [6:0] ev_key, h_key;
  logic [8:0] shift;
  logic [7:0] exp_q[$];
  int         err_total, samples_checked, rx_n, wire_n, nbit, tmo;
  kbl_link_if l1 ();
  kbl_link_if l2 ();
  kbl_keyboard #(.DEPTH(4), .TIMEOUT_CYC(64)) kbl_keyboard_i (.i_clk(clk), .i_rstn(rstn),
    .i_ev_valid(ev_valid), .i_ev_closed(ev_closed), .i_ev_key(ev_key), .o_ev_ready(k_ready),
    .o_holdoff(k_hold), .o_retry(k_retry), .link(l1));
  kbl_keyboard #(.DEPTH(4), .TIMEOUT_CYC(64)) kbl_keyboard_i2 (.i_clk(clk), .i_rstn(rstn),
    .i_ev_valid(ev2_valid), .i_ev_closed(ev_closed), .i_ev_key(7'h02), .o_ev_ready(k2_rdy),
    .o_holdoff(), .o_retry(k2_retry), .link(l2));
  kbl_host kbl_host_i (.i_clk(clk), .i_rstn(rstn), .o_ev_valid(h_valid),
    .o_ev_closed(h_closed), .o_ev_key(h_key), .o_frame_err(h_err), .link(l1));
  kbl_link_monitor kbl_link_monitor_i (.i_clk(clk), .i_rstn(rstn), .data(l1.data),
    .ready(l1.ready), .ack(l1.ack));
  always #5 clk = ~clk;
  // ==========
  // helpers
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic step(input int lim);
    @(posedge clk);
    tmo++;
    if (tmo > lim)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic send(input logic closed, input logic [6:0] key);
    @(posedge clk);
    ev_valid  <= 1'b1;
    ev_closed <= closed;
    ev_key    <= key;
    exp_q.push_back({closed, key});
    tmo = 0;
    do
      step(5000);
    while (k_ready !== 1'b1);
    ev_valid <= 1'b0;
  endtask
  // ==========
  // observers
  always @(posedge clk)
  begin
    if (k_hold === 1'b1)
      hold_seen = 1'b1;
    if (h_err === 1'b1)
      check(9'h1, 9'h0);
    if (h_valid === 1'b1)
    begin
      check({1'b0, h_closed, h_key}, {1'b0, exp_q[rx_n]});
      rx_n++;
    end
    if (l1.ack === 1'b1 && ack_q === 1'b0)
    begin
      shift = {l1.data, shift[8:1]};
      nbit++;
      if (nbit == 9)
      begin
        check(shift, {KBL_STOP_LEVEL, exp_q[wire_n]});
        wire_n++;
        nbit = 0;
      end
    end
    ack_q = l1.ack;
  end
  // ==========
  // sequence
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    ev_valid = 1'b0;
    ev_closed = 1'b0;
    ev_key = 7'h00;
    ev2_valid = 1'b0;
    l2.ack = 1'b0;
    hold_seen = 1'b0;
    ack_q = 1'b0;
    shift = 9'h000;
    err_total = 0;
    samples_checked = 0;
    rx_n = 0;
    wire_n = 0;
    nbit = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++)
      send(i < 6, 7'h7f - 7'(i % 6) * 7'h19);
    tmo = 0;
    while (rx_n < 12)
      step(20000);
    check(9'(hold_seen), 9'h1);
    check(9'(wire_n), 9'd12);
    @(posedge clk);
    ev2_valid <= 1'b1;
    tmo = 0;
    do
      step(100);
    while (k2_rdy !== 1'b1);
    ev2_valid <= 1'b0;
    tmo = 0;
    while (l2.ready !== 1'b1)
      step(200);
    check(9'(l2.data), 9'h0);
    l2.ack <= 1'b1;
    tmo = 0;
    while (l2.ready !== 1'b0)
      step(200);
    l2.ack <= 1'b0;
    tmo = 0;
    while (l2.ready !== 1'b1)
      step(200);
    check(9'(l2.data), 9'h1);
    tmo = 0;
    while (k2_retry !== 1'b1)
      step(200);
    tmo = 0;
    while (l2.ready !== 1'b1 || l2.data !== 1'b0)
      step(200);
    check(9'(l2.data), 9'h0);
    stop_test();
  end
endmodule
`default_nettype wire
